// >>> design/tdcr_pkg.sv
// Summary of operation
// - word zero bit 0 starts ring oscillator
// - bits 1,2 differential start edges, two-channel modes
// - bits 3,4 first differential stop edges
// - bits 5,6 second differential stop edges
// - eight-channel mode bits 10-18 rising edges
// - eight-channel mode bits 19-27 falling edges
// - word one holds seven 4-bit channel trims
// - word two bits 0-2 select modes
// - word two bits 3-11 disable channels
// - word two holds trims seven and eight
// - all configuration words read back written value
// - bin size from reference period and dividers
// - lost lock runs floating until relock
// - fine factor divides triple bin by factor+1
package tdcr_pkg;
   // ------------------------------------------------------------
   // register indices, byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [3:0] REG_EDGE_OSC_IDX = 4'h0;
   localparam logic [3:0] REG_TRIM_LOW_IDX = 4'h1;
   localparam logic [3:0] REG_MODE_DIS_IDX = 4'h2;
   localparam logic [3:0] REG_FINE_IDX = 4'h3;
   localparam logic [3:0] REG_DIVIDER_IDX = 4'h7;
   localparam logic [3:0] REG_STATUS_IDX = 4'h8;
   localparam logic [3:0] REG_BIN_IDX = 4'h9;
   localparam int REG_W = 28;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int F_RING_OSC = 0;
   localparam int F_START_RISE = 1;
   localparam int F_START_FALL = 2;
   localparam int F_STOP_A_RISE = 3;
   localparam int F_STOP_A_FALL = 4;
   localparam int F_STOP_B_RISE = 5;
   localparam int F_STOP_B_FALL = 6;
   localparam int F_QSERV_LO = 7;
   localparam int F_SE_RISE_LO = 10;
   localparam int F_SE_FALL_LO = 19;
   localparam int F_MODE_DOUBLE = 0;
   localparam int F_MODE_EIGHT = 1;
   localparam int F_MODE_TRIPLE = 2;
   localparam int F_DISABLE_LO = 3;
   localparam int F_TRIM7_LO = 12;
   localparam int F_TRIM8_LO = 16;
   localparam int F_DSERV_LO = 20;
   localparam int F_FINE_LO = 0;
   localparam int F_REFDIV_LO = 0;
   localparam int F_HSDIV_LO = 4;
   localparam int F_FINE_SEL = 12;
   localparam int N_CHAN = 9;
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [27:0] RST_EDGE_OSC = 28'h0000000;
   localparam logic [27:0] RST_TRIM_LOW = 28'h0000000;
   localparam logic [27:0] RST_MODE_DIS = 28'h0000000;
   localparam logic [27:0] RST_FINE = 28'h0000000;
   localparam logic [27:0] RST_DIVIDER = 28'h0000010;
   // ------------------------------------------------------------
   // timing and resolution constants
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 10000;
   localparam int TREF_NS = 25;
   localparam logic [31:0] TREF_FS = 32'(TREF_NS * 1000000);
   localparam logic [15:0] BIN_DIVISOR = 16'h00d8;
   localparam int RELOCK_NS = 1000;
   localparam int RELOCK_CYC = (RELOCK_NS * 1000) / CLK_PERIOD_PS;
   localparam int DIV_STEPS = 32;

   typedef enum logic [2:0] {MODE_NONE, MODE_DOUBLE, MODE_EIGHT, MODE_TRIPLE, MODE_FINE} tdcr_mode_e;

   // mode decode, triple wins over double wins over eight
   function automatic tdcr_mode_e tdcr_mode(input logic [27:0] w2, input logic fine_sel);
      if (w2[F_MODE_TRIPLE]) begin
         return fine_sel ? MODE_FINE : MODE_TRIPLE;
      end else if (w2[F_MODE_DOUBLE]) begin
         return MODE_DOUBLE;
      end else if (w2[F_MODE_EIGHT]) begin
         return MODE_EIGHT;
      end
      return MODE_NONE;
   endfunction : tdcr_mode
endpackage : tdcr_pkg

// >>> design/tdcr_div_if.sv
`timescale 1ns/10ps
`default_nettype none
interface tdcr_div_if;
   logic start;
   logic [31:0] num;
   logic [31:0] den;
   logic busy;
   logic done;
   logic [31:0] quot;
   modport master (output start, output num, output den, input busy, input done, input quot);
   modport slave (input start, input num, input den, output busy, output done, output quot);
endinterface : tdcr_div_if
`default_nettype wire

// >>> design/tdcr_div.sv
`timescale 1ns/10ps
`default_nettype none
module tdcr_div
   import tdcr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // divide job
   tdcr_div_if.slave div
);
   typedef enum logic {DIV_IDLE, DIV_RUN} tdcr_div_e;
   tdcr_div_e state_reg, state_next;
   logic [32:0] rem_reg, rem_next;
   logic [31:0] q_reg, q_next;
   logic [31:0] den_reg, den_next;
   logic [5:0] cnt_reg, cnt_next;
   logic done_reg, done_next;
   logic [32:0] rem_sh;

   // ------------------------------------------------------------
   // restoring divider, one quotient bit per cycle
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      rem_next = rem_reg;
      q_next = q_reg;
      den_next = den_reg;
      cnt_next = cnt_reg;
      done_next = 1'b0;
      rem_sh = {rem_reg[31:0], q_reg[31]};
      unique case (state_reg)
         DIV_IDLE: begin
            if (div.start) begin
               rem_next = 33'h0;
               q_next = div.num;
               den_next = div.den;
               cnt_next = 6'h00;
               state_next = DIV_RUN;
            end
         end
         DIV_RUN: begin
            if (rem_sh >= {1'b0, den_reg}) begin
               rem_next = rem_sh - {1'b0, den_reg};
               q_next = {q_reg[30:0], 1'b1};
            end else begin
               rem_next = rem_sh;
               q_next = {q_reg[30:0], 1'b0};
            end
            cnt_next = cnt_reg + 6'h01;
            if (cnt_reg == 6'(DIV_STEPS - 1)) begin
               done_next = 1'b1;
               state_next = DIV_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= DIV_IDLE;
         rem_reg <= 33'h0;
         q_reg <= 32'h00000000;
         den_reg <= 32'h00000000;
         cnt_reg <= 6'h00;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         rem_reg <= rem_next;
         q_reg <= q_next;
         den_reg <= den_next;
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign div.busy = (state_reg == DIV_RUN);
   assign div.done = done_reg;
   assign div.quot = q_reg;
endmodule : tdcr_div
`default_nettype wire

// >>> design/tdcr_lock_mon.sv
`timescale 1ns/10ps
`default_nettype none
module tdcr_lock_mon
   import tdcr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // loop conditions
   input wire logic osc_run_i,
   input wire logic unlock_i,
   // state
   output logic locked_o,
   output logic floating_o
);
   typedef enum logic [1:0] {LK_OFF, LK_FLOAT, LK_LOCKED} tdcr_lock_e;
   tdcr_lock_e state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;

   // ------------------------------------------------------------
   // floating until the loop has been quiet for the relock time
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      unique case (state_reg)
         LK_OFF: begin
            cnt_next = 16'h0000;
            if (osc_run_i) begin
               state_next = LK_FLOAT;
            end
         end
         LK_FLOAT: begin
            if (unlock_i) begin
               cnt_next = 16'h0000;
            end else if (cnt_reg == 16'(RELOCK_CYC - 1)) begin
               state_next = LK_LOCKED;
            end else begin
               cnt_next = cnt_reg + 16'h0001;
            end
         end
         LK_LOCKED: begin
            cnt_next = 16'h0000;
            if (unlock_i) begin
               state_next = LK_FLOAT;
            end
         end
      endcase
      if (!osc_run_i) begin
         state_next = LK_OFF;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= LK_OFF;
         cnt_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign locked_o = (state_reg == LK_LOCKED);
   assign floating_o = (state_reg == LK_FLOAT);

   a_lock_loss: assert property (@(posedge clk_i) disable iff (rst_i)
      locked_o && unlock_i && osc_run_i |=> floating_o)
      else $error("lock loss did not enter floating");
   a_relock_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(locked_o) |-> $past(floating_o) && !$past(unlock_i))
      else $error("relocked while loop was disturbed");
   c_relock: cover property (@(posedge clk_i) disable iff (rst_i) floating_o ##1 locked_o);
endmodule : tdcr_lock_mon
`default_nettype wire

// >>> design/tdcr_config_regs.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module tdcr_config_regs
   import tdcr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // resolution loop pin
   input wire logic loop_unlock_i,
   // oscillator and differential edges
   output logic ring_osc_start_o,
   output logic start_diff_rise_en_o,
   output logic start_diff_fall_en_o,
   output logic stop_a_diff_rise_en_o,
   output logic stop_a_diff_fall_en_o,
   output logic stop_b_diff_rise_en_o,
   output logic stop_b_diff_fall_en_o,
   // single-ended edges, bit 0 start, bit 8 stop eight
   output logic [8:0] single_ended_rise_mask_o,
   output logic [8:0] single_ended_fall_mask_o,
   // mode, channels and trims
   output logic mode_double_o,
   output logic mode_eight_o,
   output logic mode_triple_o,
   output logic mode_fine_o,
   output logic [8:0] chan_disable_o,
   output logic [35:0] trim_o,
   output logic [4:0] fine_factor_o,
   output logic [2:0] quality_service_field_o,
   output logic [7:0] delay_service_o,
   // resolution loop
   output logic [2:0] ref_div_pow_o,
   output logic [7:0] hs_div_o,
   output logic [31:0] bin_fs_o,
   output logic bin_valid_o,
   output logic res_locked_o,
   output logic res_floating_o
);
   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [27:0] cfg_reg [0:4];
   logic [27:0] cfg_next [0:4];
   localparam logic [3:0] CFG_IDX [0:4] = '{REG_EDGE_OSC_IDX, REG_TRIM_LOW_IDX, REG_MODE_DIS_IDX,
                                             REG_FINE_IDX, REG_DIVIDER_IDX};
   localparam logic [27:0] CFG_RST [0:4] = '{RST_EDGE_OSC, RST_TRIM_LOW, RST_MODE_DIS, RST_FINE,
                                             RST_DIVIDER};
   logic ack_reg, ack_next;
   logic [31:0] rdat_reg, rdat_next;
   logic dirty_reg, dirty_next;
   logic bin_valid_reg, bin_valid_next;
   logic [31:0] bin_reg, bin_next;
   logic unlock_s1_reg, unlock_s2_reg;
   logic req;
   logic wr;
   logic [3:0] idx;
   logic [27:0] lane_mask;
   tdcr_mode_e mode;
   logic locked, floating;
   tdcr_div_if div ();

   assign req = wb_cyc_i && wb_stb_i && !ack_reg;
   assign wr = req && wb_we_i;
   assign idx = wb_adr_i[5:2];
   assign lane_mask = {{4{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign mode = tdcr_mode(cfg_reg[2], cfg_reg[4][F_FINE_SEL]);

   // ------------------------------------------------------------
   // bus slave: ack one cycle after the request, read from flops
   // ------------------------------------------------------------
   always_comb begin
      ack_next = req;
      rdat_next = 32'h00000000;
      for (int i = 0; i < 5; i++) begin
         cfg_next[i] = cfg_reg[i];
         if (wr && idx == CFG_IDX[i]) begin
            cfg_next[i] = (cfg_reg[i] & ~lane_mask) | (wb_dat_i[27:0] & lane_mask);
         end
         if (req && idx == CFG_IDX[i]) begin
            rdat_next = {4'h0, cfg_reg[i]};
         end
      end
      if (req && idx == REG_STATUS_IDX) begin
         rdat_next = {25'h0, mode, bin_valid_reg, div.busy, floating, locked};
      end
      if (req && idx == REG_BIN_IDX) begin
         rdat_next = bin_reg;
      end
   end

   // ------------------------------------------------------------
   // bin size: recompute whenever a divider or mode field changes
   // ------------------------------------------------------------
   always_comb begin
      logic [31:0] k;
      k = 32'h00000001;
      unique case (mode)
         MODE_DOUBLE: k = 32'h00000002;
         MODE_TRIPLE: k = 32'h00000003;
         MODE_FINE: k = 32'h00000003 * (32'(cfg_reg[3][F_FINE_LO +: 5]) + 32'h00000001);
         MODE_EIGHT, MODE_NONE: k = 32'h00000001;
      endcase
      div.num = TREF_FS << cfg_reg[4][F_REFDIV_LO +: 3];
      div.den = 32'(BIN_DIVISOR) * 32'(cfg_reg[4][F_HSDIV_LO +: 8]) * k;
      div.start = dirty_reg && !div.busy && !div.done;
      dirty_next = dirty_reg;
      if (div.start) begin
         dirty_next = 1'b0;
      end
      if (wr && (idx == REG_MODE_DIS_IDX || idx == REG_FINE_IDX || idx == REG_DIVIDER_IDX)) begin
         dirty_next = 1'b1;
      end
      bin_valid_next = bin_valid_reg;
      bin_next = bin_reg;
      if (dirty_next) begin
         bin_valid_next = 1'b0;
      end else if (div.done) begin
         bin_valid_next = 1'b1;
         bin_next = div.quot;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         rdat_reg <= 32'h00000000;
         dirty_reg <= 1'b1;
         bin_valid_reg <= 1'b0;
         bin_reg <= 32'h00000000;
         for (int i = 0; i < 5; i++) begin
            cfg_reg[i] <= CFG_RST[i];
         end
      end else begin
         ack_reg <= ack_next;
         rdat_reg <= rdat_next;
         dirty_reg <= dirty_next;
         bin_valid_reg <= bin_valid_next;
         bin_reg <= bin_next;
         for (int i = 0; i < 5; i++) begin
            cfg_reg[i] <= cfg_next[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         unlock_s1_reg <= 1'b0;
         unlock_s2_reg <= 1'b0;
      end else begin
         unlock_s1_reg <= loop_unlock_i;
         unlock_s2_reg <= unlock_s1_reg;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   tdcr_div u_div (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .div(div.slave)
   );

   tdcr_lock_mon u_lock (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .osc_run_i(cfg_reg[0][F_RING_OSC]),
      .unlock_i(unlock_s2_reg),
      .locked_o(locked),
      .floating_o(floating)
   );

   // ------------------------------------------------------------
   // configuration outputs, edge enables gated by mode and disables
   // ------------------------------------------------------------
   logic [8:0] dis;
   logic two_ch, eight_ch;
   logic [35:0] trim_all;
   logic [8:0] se_rise_next, se_fall_next;
   logic [6:0] diff_next;
   logic [35:0] trim_next;
   logic [3:0] mode_next;
   assign dis = cfg_reg[2][F_DISABLE_LO +: N_CHAN];
   assign two_ch = (mode == MODE_DOUBLE) || (mode == MODE_TRIPLE) || (mode == MODE_FINE);
   assign eight_ch = (mode == MODE_EIGHT);
   assign trim_all = {cfg_reg[2][F_TRIM8_LO +: 4], cfg_reg[2][F_TRIM7_LO +: 4], cfg_reg[1]};

   always_comb begin
      diff_next[0] = cfg_reg[0][F_RING_OSC];
      diff_next[1] = two_ch && !dis[0] && cfg_reg[0][F_START_RISE];
      diff_next[2] = two_ch && !dis[0] && cfg_reg[0][F_START_FALL];
      diff_next[3] = two_ch && !dis[1] && cfg_reg[0][F_STOP_A_RISE];
      diff_next[4] = two_ch && !dis[1] && cfg_reg[0][F_STOP_A_FALL];
      diff_next[5] = two_ch && !dis[2] && cfg_reg[0][F_STOP_B_RISE];
      diff_next[6] = two_ch && !dis[2] && cfg_reg[0][F_STOP_B_FALL];
      se_rise_next = eight_ch ? (cfg_reg[0][F_SE_RISE_LO +: N_CHAN] & ~dis) : 9'h000;
      se_fall_next = eight_ch ? (cfg_reg[0][F_SE_FALL_LO +: N_CHAN] & ~dis) : 9'h000;
      trim_next = two_ch ? trim_all : 36'h000000000;
      mode_next = {mode == MODE_FINE, mode == MODE_TRIPLE || mode == MODE_FINE, eight_ch,
                   mode == MODE_DOUBLE};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {stop_b_diff_fall_en_o, stop_b_diff_rise_en_o, stop_a_diff_fall_en_o, stop_a_diff_rise_en_o,
          start_diff_fall_en_o, start_diff_rise_en_o, ring_osc_start_o} <= 7'h00;
         single_ended_rise_mask_o <= 9'h000;
         single_ended_fall_mask_o <= 9'h000;
         trim_o <= 36'h000000000;
         {mode_fine_o, mode_triple_o, mode_eight_o, mode_double_o} <= 4'h0;
         chan_disable_o <= 9'h000;
         fine_factor_o <= 5'h00;
         quality_service_field_o <= 3'h0;
         delay_service_o <= 8'h00;
         ref_div_pow_o <= 3'h0;
         hs_div_o <= 8'h00;
         bin_fs_o <= 32'h00000000;
         bin_valid_o <= 1'b0;
         res_locked_o <= 1'b0;
         res_floating_o <= 1'b0;
      end else begin
         {stop_b_diff_fall_en_o, stop_b_diff_rise_en_o, stop_a_diff_fall_en_o, stop_a_diff_rise_en_o,
          start_diff_fall_en_o, start_diff_rise_en_o, ring_osc_start_o} <= diff_next;
         single_ended_rise_mask_o <= se_rise_next;
         single_ended_fall_mask_o <= se_fall_next;
         trim_o <= trim_next;
         {mode_fine_o, mode_triple_o, mode_eight_o, mode_double_o} <= mode_next;
         chan_disable_o <= dis;
         fine_factor_o <= cfg_reg[3][F_FINE_LO +: 5];
         quality_service_field_o <= cfg_reg[0][F_QSERV_LO +: 3];
         delay_service_o <= cfg_reg[2][F_DSERV_LO +: 8];
         ref_div_pow_o <= cfg_reg[4][F_REFDIV_LO +: 3];
         hs_div_o <= cfg_reg[4][F_HSDIV_LO +: 8];
         bin_fs_o <= bin_reg;
         bin_valid_o <= bin_valid_reg;
         res_locked_o <= locked;
         res_floating_o <= floating;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   a_readback_trim: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
      && wb_adr_i[5:2] == REG_TRIM_LOW_IDX |=> wb_dat_o == {4'h0, $past(cfg_reg[1])})
      else $error("register did not read back written value");
   a_osc_start: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
      && wb_adr_i[5:2] == REG_EDGE_OSC_IDX |-> ##2 ring_osc_start_o == $past(wb_dat_i[F_RING_OSC], 2))
      else $error("ring oscillator start does not follow write");
   a_se_mode_only: assert property ((single_ended_rise_mask_o | single_ended_fall_mask_o) != 9'h000
      |-> mode_eight_o)
      else $error("single-ended edges enabled outside eight-channel mode");
   a_diff_mode_only: assert property (start_diff_rise_en_o || start_diff_fall_en_o || stop_a_diff_rise_en_o
      || stop_b_diff_fall_en_o |-> !mode_eight_o)
      else $error("differential edges enabled in eight-channel mode");
   a_disable_masks: assert property (((single_ended_rise_mask_o | single_ended_fall_mask_o)
      & chan_disable_o) == 9'h000)
      else $error("disabled channel still has an edge enabled");
   a_mode_onehot: assert property ($onehot0({mode_double_o, mode_eight_o, mode_triple_o}))
      else $error("more than one mode active");
   a_bin_time: assert property (div.start |-> ##[32:34] div.done)
      else $error("bin computation overran");
   a_bin_value: assert property ($rose(bin_valid_reg) && mode == MODE_EIGHT
      |-> bin_reg == div.num / div.den)
      else $error("bin size differs from reference formula");
   c_write_osc: cover property (wb_ack_o && wb_we_i && wb_adr_i[5:2] == REG_EDGE_OSC_IDX);
   c_read_mode: cover property (wb_ack_o && !wb_we_i && wb_adr_i[5:2] == REG_MODE_DIS_IDX);
   c_bin_ready: cover property ($rose(bin_valid_o) && mode_fine_o);
   c_float: cover property ($rose(res_floating_o));
endmodule : tdcr_config_regs
`default_nettype wire

// >>> bench/tdcr_host.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// host model: classic wishbone master
// ------------------------------------------------------------
module tdcr_host (
   // clock
   input wire logic clk_i,
   // wishbone master
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [5:0] adr_o,
   output logic [31:0] dat_o,
   input wire logic [31:0] dat_i,
   input wire logic ack_i
);
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 6'h00;
      dat_o = 32'h0;
   end
   // entered just after a rising edge; holds until ack is sampled
   task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      dat_o <= d;
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      r = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      @(posedge clk_i);
   endtask : xfer
endmodule : tdcr_host
`default_nettype wire

// >>> bench/time_digitizer_config_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module time_digitizer_config_regs_tb;
   import tdcr_pkg::*;
   logic clk_i, rst_i, unlock, cyc, stb, we, ack;
   logic [5:0] adr;
   logic [31:0] wdat, rdat, bin;
   logic [8:0] rmask, fmask, dis;
   logic [35:0] trim;
   logic [2:0] qsf, rdp;
   logic [4:0] ff;
   logic [7:0] dsv, hdv;
   logic osc, srise, sfall, arise, afall, brise, bfall, m2, m8, m3, mf, valid, lck, flt;
   int err_count, n_compared, cyc_cnt;
   tdcr_host host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .dat_o(wdat),
      .dat_i(rdat), .ack_i(ack));
   tdcr_config_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .loop_unlock_i(unlock), .ring_osc_start_o(osc), .start_diff_rise_en_o(srise),
      .start_diff_fall_en_o(sfall), .stop_a_diff_rise_en_o(arise), .stop_a_diff_fall_en_o(afall),
      .stop_b_diff_rise_en_o(brise), .stop_b_diff_fall_en_o(bfall), .single_ended_rise_mask_o(rmask),
      .single_ended_fall_mask_o(fmask), .mode_double_o(m2), .mode_eight_o(m8), .mode_triple_o(m3),
      .mode_fine_o(mf), .chan_disable_o(dis), .trim_o(trim), .fine_factor_o(ff), .quality_service_field_o(qsf),
      .delay_service_o(dsv), .ref_div_pow_o(rdp), .hs_div_o(hdv), .bin_fs_o(bin), .bin_valid_o(valid),
      .res_locked_o(lck), .res_floating_o(flt));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [3:0] i, input logic [27:0] d);
      logic [31:0] r;
      host.xfer(1'b1, {i, 2'b00}, {4'h0, d}, r);
      repeat (3) @(posedge clk_i);
   endtask : wr
   task automatic rd(input logic [3:0] i, input logic [27:0] e);
      logic [31:0] r;
      host.xfer(1'b0, {i, 2'b00}, 32'h0, r);
      chk("read data", {8'h00, e}, {4'h0, r});
   endtask : rd
   // bin recompute can take two divider runs, within the 100-cycle wait
   task automatic chk_bin(input logic [31:0] e);
      int n;
      n = 0;
      while (valid !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      chk("bin valid", 1'b1, valid);
      chk("bin size", {4'h0, e}, {4'h0, bin});
   endtask : chk_bin
   task automatic t_regs();
      rd(4'h0, 28'h0);
      rd(4'h2, 28'h0);
      wr(4'h1, 28'ha5c3e96);
      rd(4'h1, 28'ha5c3e96);
      rd(4'h5, 28'h0);
   endtask : t_regs
   task automatic t_eight();
      wr(4'h2, 28'h0000012);
      wr(4'h0, 28'hffffcff);
      rd(4'h0, 28'hffffcff);
      chk("eight pins", {3'b101, 3'b001, 3'b000, 9'h1fd, 9'h1fd},
         {m8, m3, osc, qsf, srise, arise, brise, rmask, fmask});
      chk_bin(32'(25000000 / 216));
   endtask : t_eight
   task automatic t_triple();
      wr(4'h1, 28'h0620620);
      wr(4'h2, 28'h006200c);
      chk("triple pins", {7'h4f, 9'h0, 9'h001}, {m3, srise, sfall, arise, afall, brise, bfall, rmask, dis});
      chk("triple trim", {4'h6, 4'h2, 28'h0620620}, trim);
      chk_bin(32'(25000000 / 648));
      wr(4'h1, 28'h5050500);
      wr(4'h2, 28'h0050001);
      chk("double mode", 2'b10, {m2, m3});
      chk("double trim", {4'h5, 4'h0, 28'h5050500}, trim);
      chk_bin(32'(25000000 / 432));
   endtask : t_triple
   task automatic t_fine();
      wr(4'h3, 28'h0000002);
      wr(4'h7, 28'h0001011);
      wr(4'h2, 28'h0000004);
      chk("fine pins", {3'b110, 5'h02, 8'h00, 3'h1, 8'h01}, {m3, mf, m2, ff, dsv, rdp, hdv});
      chk_bin(32'(50000000 / 1944));
   endtask : t_fine
   task automatic t_lock();
      repeat (110) @(posedge clk_i);
      chk("locked", 2'b10, {lck, flt});
      unlock <= 1'b1;
      repeat (5) @(posedge clk_i);
      chk("floating", 2'b01, {lck, flt});
      unlock <= 1'b0;
      repeat (110) @(posedge clk_i);
      chk("relocked", 2'b10, {lck, flt});
   endtask : t_lock
   task automatic final_report();
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report
   always @(posedge clk_i) begin
      cyc_cnt++;
      if (cyc_cnt == 5000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      rst_i = 1'b1;
      unlock = 1'b0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_eight();
      t_triple();
      t_fine();
      t_lock();
      final_report();
   end
endmodule : time_digitizer_config_regs_tb
`default_nettype wire
